/* verilog/mul_pkg.sv */
// Purpose: Shared constants for the unsigned byte multiplier
// Assumes: Byte-wide register port, 12-bit register address
// Notes:   Result pair sits low byte first at two consecutive addresses
`default_nettype none

package mul_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int OPERAND_W = 8;
    localparam int PRODUCT_W = 16;
    localparam int ADDR_W    = 12;
    localparam int STATUS_W  = 5;
    localparam int HIGH_LSB  = 8;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [ADDR_W-1:0]    ADDR_RESULT_LOW  = 12'hff3;
    localparam logic [ADDR_W-1:0]    ADDR_RESULT_HIGH = 12'hff4;
    localparam logic [PRODUCT_W-1:0] RESULT_RESET     = 16'h0000;
    localparam logic [OPERAND_W-1:0] READ_IDLE        = 8'h00;

endpackage : mul_pkg

`default_nettype wire

/* verilog/byte_product_core.sv */
// Purpose: Combinational unsigned 8 by 8 product
// Assumes: Operands stable for the whole cycle of the command
// Notes:   Pure logic, no state; the caller registers the result
`default_nettype none

module byte_product_core
    import mul_pkg::*;
(
    input  wire logic [mul_pkg::OPERAND_W-1:0] OPERAND_A,
    input  wire logic [mul_pkg::OPERAND_W-1:0] OPERAND_B,
    output logic      [mul_pkg::PRODUCT_W-1:0] PRODUCT
);

    // ************************************************************
    // Product
    // ************************************************************
    // Both operands widened to 16 bits so no carry is lost
    assign PRODUCT = PRODUCT_W'(OPERAND_A) * PRODUCT_W'(OPERAND_B);

endmodule // byte_product_core

`default_nettype wire

/* verilog/unsigned_byte_multiplier.sv */
// Purpose: Unsigned byte multiplier with a software visible result pair
// Assumes: Sequencer drives operands and command on the same clock
// Notes:   Result pair resets to 16'h0000; software must not rely on it
//
// What this block does
// - Multiply two bytes unsigned, full 16-bit product
// - High byte bits 15:8, low byte 7:0
// - Multiply never changes any status flag
// - Whole multiply finishes in one cycle
// - One command: working register times file operand
// - Both result bytes read and write; reset undefined (this block resets them to 16'h0000)
//
// Added by the designer: strobed register access.
`default_nettype none

module unsigned_byte_multiplier
    import mul_pkg::*;
(
    input  wire logic                          REF_CLK,
    input  wire logic                          RST_N,
    input  wire logic                          MUL_GO,
    input  wire logic [mul_pkg::OPERAND_W-1:0] WORKING_REGISTER,
    input  wire logic [mul_pkg::OPERAND_W-1:0] FILE_OPERAND,
    input  wire logic [mul_pkg::STATUS_W-1:0]  STATUS_IN,
    output logic      [mul_pkg::STATUS_W-1:0]  STATUS_OUT,
    input  wire logic [mul_pkg::ADDR_W-1:0]    REG_ADDR,
    input  wire logic [mul_pkg::OPERAND_W-1:0] REG_WDATA,
    input  wire logic                          REG_WR,
    input  wire logic                          REG_RD,
    output logic      [mul_pkg::OPERAND_W-1:0] REG_RDATA,
    output logic      [mul_pkg::OPERAND_W-1:0] RESULT_HIGH_BYTE,
    output logic      [mul_pkg::OPERAND_W-1:0] RESULT_LOW_BYTE,
    output logic                               MUL_DONE
);
    import mul_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [PRODUCT_W-1:0] result_pair;
        logic [OPERAND_W-1:0] read_data;
        logic                 done;
    } mul_state_t;

    mul_state_t           state;
    mul_state_t           next_state;
    logic [PRODUCT_W-1:0] core_product;

    function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] target);
        hits = (addr == target);
    endfunction

    // ************************************************************
    // Multiplier core
    // ************************************************************
    // Operands wired straight from the sequencer; no extra fetch needed
    byte_product_core u_core (
        .OPERAND_A (WORKING_REGISTER),
        .OPERAND_B (FILE_OPERAND),
        .PRODUCT   (core_product)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_state           = state;
        next_state.done      = MUL_GO;
        next_state.read_data = READ_IDLE;
        // Read samples the value before any write of the same cycle
        if (REG_RD) begin
            if (hits(REG_ADDR, ADDR_RESULT_LOW)) begin
                next_state.read_data = state.result_pair[HIGH_LSB-1:0];
            end else if (hits(REG_ADDR, ADDR_RESULT_HIGH)) begin
                next_state.read_data = state.result_pair[PRODUCT_W-1:HIGH_LSB];
            end
        end
        if (REG_WR) begin
            if (hits(REG_ADDR, ADDR_RESULT_LOW)) begin
                next_state.result_pair[HIGH_LSB-1:0] = REG_WDATA;
            end else if (hits(REG_ADDR, ADDR_RESULT_HIGH)) begin
                next_state.result_pair[PRODUCT_W-1:HIGH_LSB] = REG_WDATA;
            end
        end
        // Placed last so a multiply beats a software write in the same cycle
        if (MUL_GO) begin
            next_state.result_pair = core_product;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state.result_pair <= RESULT_RESET;
            state.read_data   <= READ_IDLE;
            state.done        <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Flags pass untouched; the multiplier has no path into them
    assign STATUS_OUT       = STATUS_IN;
    assign REG_RDATA        = state.read_data;
    assign RESULT_HIGH_BYTE = state.result_pair[PRODUCT_W-1:HIGH_LSB];
    assign RESULT_LOW_BYTE  = state.result_pair[HIGH_LSB-1:0];
    assign MUL_DONE         = state.done;

    // ************************************************************
    // Checks
    // ************************************************************
    // ************************************************************
    // Reference product
    // ************************************************************
    // Shift and add, kept apart from the core's multiply operator
    // so a fault in the core cannot hide in its own expectation
    function automatic logic [PRODUCT_W-1:0] shift_add(input logic [OPERAND_W-1:0] a,
                                                      input logic [OPERAND_W-1:0] b);
        logic [PRODUCT_W-1:0] acc;
        acc = '0;
        for (int i = 0; i < OPERAND_W; i++) begin
            if (b[i]) begin
                acc = acc + (PRODUCT_W'(a) << i);
            end
        end
        shift_add = acc;
    endfunction

    logic [PRODUCT_W-1:0] expect_product;
    assign expect_product = shift_add(WORKING_REGISTER, FILE_OPERAND);

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    a_product_value: assert property (
        MUL_GO |=> {RESULT_HIGH_BYTE, RESULT_LOW_BYTE} == $past(expect_product))
        else $error("product differs from unsigned operand product");

    a_high_byte_split: assert property (
        MUL_GO |=> RESULT_HIGH_BYTE == $past(expect_product[PRODUCT_W-1:HIGH_LSB])
                   && RESULT_LOW_BYTE == $past(expect_product[HIGH_LSB-1:0]))
        else $error("product bytes placed in wrong halves");

    a_flags_unchanged: assert property (
        STATUS_OUT == STATUS_IN)
        else $error("status flags altered by multiplier");

    a_single_cycle: assert property (
        MUL_GO |=> MUL_DONE)
        else $error("multiply not complete after one cycle");

    a_done_cause: assert property (
        MUL_DONE |-> $past(MUL_GO))
        else $error("done without a multiply command");

    a_sw_write_low: assert property (
        REG_WR && !MUL_GO && hits(REG_ADDR, ADDR_RESULT_LOW)
        |=> RESULT_LOW_BYTE == $past(REG_WDATA) && $stable(RESULT_HIGH_BYTE))
        else $error("software write to low byte lost");

    a_read_back: assert property (
        REG_RD && hits(REG_ADDR, ADDR_RESULT_HIGH) && !MUL_GO
        ##1 !REG_WR && !MUL_GO
        |-> REG_RDATA == RESULT_HIGH_BYTE)
        else $error("high byte read returns wrong value");

    a_mul_overrides: assert property (
        MUL_GO && REG_WR |=> {RESULT_HIGH_BYTE, RESULT_LOW_BYTE} == $past(expect_product))
        else $error("software write beat a multiply");

    a_pair_holds: assert property (
        !MUL_GO && !REG_WR |=> $stable({RESULT_HIGH_BYTE, RESULT_LOW_BYTE}))
        else $error("result pair changed with no cause");

    // ************************************************************
    // Register port checks
    // ************************************************************
    a_sw_write_high: assert property (
        REG_WR && !MUL_GO && hits(REG_ADDR, ADDR_RESULT_HIGH)
        |=> RESULT_HIGH_BYTE == $past(REG_WDATA) && $stable(RESULT_LOW_BYTE))
        else $error("software write to high byte lost");

    a_read_low: assert property (
        REG_RD && hits(REG_ADDR, ADDR_RESULT_LOW)
        |=> REG_RDATA == $past(RESULT_LOW_BYTE))
        else $error("low byte read returns wrong value");

    // Old value even when a multiply lands in the same cycle
    a_read_high_old: assert property (
        REG_RD && hits(REG_ADDR, ADDR_RESULT_HIGH)
        |=> REG_RDATA == $past(RESULT_HIGH_BYTE))
        else $error("high byte read not the value before the edge");

    a_read_stands: assert property (
        !REG_RD |=> REG_RDATA == READ_IDLE)
        else $error("read data held past its one cycle");

    a_read_unmapped: assert property (
        REG_RD && !hits(REG_ADDR, ADDR_RESULT_LOW) && !hits(REG_ADDR, ADDR_RESULT_HIGH)
        |=> REG_RDATA == READ_IDLE)
        else $error("unmapped read returned data");

    a_unmapped_write: assert property (
        REG_WR && !MUL_GO && !hits(REG_ADDR, ADDR_RESULT_LOW)
        && !hits(REG_ADDR, ADDR_RESULT_HIGH)
        |=> $stable({RESULT_HIGH_BYTE, RESULT_LOW_BYTE}))
        else $error("unmapped write changed the result pair");

    c_back_to_back: cover property (MUL_GO ##1 MUL_GO);
    c_read_during_mul: cover property (MUL_GO && REG_RD);
    c_write_then_mul: cover property (REG_WR ##1 MUL_GO);
    c_mul_and_write: cover property (MUL_GO && REG_WR);
    c_read_after_mul: cover property (MUL_GO ##1 REG_RD);

endmodule // unsigned_byte_multiplier

`default_nettype wire

/* dv/core_seq_model.sv */
// Purpose: Core sequencer model feeding the multiplier
// Assumes: Caller syncs to the rising edge of the clock
// Notes:   Operands are scrambled once taken, never left stale
`default_nettype none

module core_seq_model
    import mul_pkg::*;
(
    input  wire logic                          clk,
    output logic                               mul_go,
    output logic      [mul_pkg::OPERAND_W-1:0] working_register,
    output logic      [mul_pkg::OPERAND_W-1:0] fop
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        mul_go = 1'b0;
        working_register = 8'h00;
        fop = 8'h00;
    end

    // One command, both operands beside it
    task automatic issue(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        mul_go <= 1'b1;
        working_register <= a;
        fop <= b;
    endtask

    // Called at an edge; inverted operands expose late sampling
    task automatic idle();
        mul_go <= 1'b0;
        working_register <= ~working_register;
        fop <= ~fop;
    endtask

    // Signed fix of the high byte after an unsigned product
    function automatic logic [7:0] fix_high(input logic [7:0] hi, a, b);
        return hi - (b[7] ? a : 8'h00) - (a[7] ? b : 8'h00);
    endfunction
endmodule // core_seq_model

`default_nettype wire

/* dv/tb_unsigned_byte_multiplier.sv */
// Purpose: Self-checking bench for the unsigned byte multiplier
// Assumes: Sequencer model drives the multiply inputs
// Notes:   Result reset value (16'h0000) is not relied on, so it is not checked
`default_nettype none

module tb_unsigned_byte_multiplier
    import mul_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk, rst_n, reg_wr, reg_rd, mul_go, done;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, rdata, hi, lo, working_register, fop;
    logic [4:0]  status_in, status_out;
    int          n_errors = 0;
    int          cmp_count = 0;

    core_seq_model SEQ (.clk(ref_clk), .mul_go(mul_go), .working_register(working_register), .fop(fop));

    unsigned_byte_multiplier DUT (
        .REF_CLK(ref_clk), .RST_N(rst_n), .MUL_GO(mul_go),
        .WORKING_REGISTER(working_register), .FILE_OPERAND(fop),
        .STATUS_IN(status_in), .STATUS_OUT(status_out),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(rdata), .RESULT_HIGH_BYTE(hi),
        .RESULT_LOW_BYTE(lo), .MUL_DONE(done));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("read data", {8'h00, rdata}, {8'h00, exp});
        @(posedge ref_clk);
        #1 chk("read idle", {8'h00, rdata}, {8'h00, READ_IDLE});
    endtask

    task automatic see_product(input logic [7:0] a, b);
        #1 chk("done", {15'h0, done}, 16'h0001);
        chk("product", {hi, lo}, 16'(a) * 16'(b));
        chk("status", {11'h0, status_out}, {11'h0, status_in});
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_mul(input logic [7:0] a, b);
        logic [15:0] p = 16'(a) * 16'(b);
        SEQ.issue(a, b);
        status_in <= a[4:0];
        @(posedge ref_clk);
        SEQ.idle();
        see_product(a, b);
        rd(ADDR_RESULT_HIGH, p[15:8]);
        rd(ADDR_RESULT_LOW, p[7:0]);
        chk("done low", {15'h0, done}, 16'h0000);
    endtask

    task automatic t_b2b();
        SEQ.issue(8'h12, 8'h34);
        SEQ.issue(8'hff, 8'h02);
        see_product(8'h12, 8'h34);
        @(posedge ref_clk);
        SEQ.idle();
        see_product(8'hff, 8'h02);
    endtask

    task automatic t_regs();
        wr(ADDR_RESULT_LOW, 8'ha5);
        wr(ADDR_RESULT_HIGH, 8'h5a);
        wr(12'h000, 8'hff);
        rd(ADDR_RESULT_LOW, 8'ha5);
        rd(ADDR_RESULT_HIGH, 8'h5a);
        rd(12'h000, READ_IDLE);
        t_mul(8'h03, 8'h07);
    endtask

    task automatic t_signed();
        t_mul(8'hfe, 8'h03);
        chk("signed", {SEQ.fix_high(hi, 8'hfe, 8'h03), lo}, 16'hfffa);
    endtask

    // Mid-run reset on the edge that takes a multiply
    task automatic t_reset();
        SEQ.issue(8'h21, 8'h43);
        @(posedge ref_clk);
        SEQ.idle();
        rst_n <= 1'b0;
        #1 chk("done in reset", {15'h0, done}, 16'h0000);
        chk("rdata in reset", {8'h00, rdata}, {8'h00, READ_IDLE});
        chk("status in reset", {11'h0, status_out}, {11'h0, status_in});
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_mul(8'h21, 8'h43);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, status_in} = '0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_mul(8'h00, 8'h00);
        t_mul(8'hff, 8'hff);
        t_mul(8'h80, 8'h02);
        t_mul(8'h0f, 8'h11);
        t_b2b();
        t_regs();
        t_signed();
        t_reset();
        conclude();
    end

    // Whole run needs about 80 cycles
    initial begin
        #50000;
        n_errors++;
        conclude();
    end
endmodule // tb_unsigned_byte_multiplier

`default_nettype wire
